// *** core/htw_pkg.sv ***
package htw_pkg;
  localparam int          ADDR_W        = 40;
  localparam int          RX_WIN_N      = 3;
  localparam int          POST_WIN_N    = 2;
  localparam int          PREF_WIN_N    = 2;
  localparam int          UNC_WIN_N     = 2;
  localparam logic [39:0] CFG_BASE      = 40'hFD_FB00_0000;
  localparam logic [39:0] CFG_LAST      = 40'hFD_FBFF_FFFF;
  localparam logic [39:0] CFG_SPAN_MASK = 40'hFF_FF00_0000;

  typedef enum logic [1:0] {
    RX_INTERNAL,
    RX_P2P,
    RX_ERROR,
    RX_CONFIG
  } rx_route_t;

  typedef enum logic [1:0] {
    TX_NONPOSTED,
    TX_POSTED,
    TX_LOCAL,
    TX_CONFIG
  } tx_route_t;
endpackage : htw_pkg

// *** core/htw_win_if.sv ***
interface htw_win_if #(
  parameter int N = 2
);
  logic [N-1:0]             en;
  logic [N-1:0][39:0]       base;
  logic [N-1:0][39:0]       mask;
  logic [39:0]              addr;
  logic                     hit;

  modport match (input en, base, mask, addr, output hit);
  modport user  (output en, base, mask, addr, input hit);
endinterface : htw_win_if

// *** core/htw_win_match.sv ***
module htw_win_match #(
  parameter int N = 2
) (
  htw_win_if.match w
);
  logic [N-1:0] each;

  // window hit when enabled and masked address equals masked base
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_win
      assign each[g] = w.en[g] && ((w.addr & w.mask[g]) == (w.base[g] & w.mask[g]));
    end
  endgenerate

  assign w.hit = |each;
endmodule : htw_win_match

// *** core/ht_address_window_filter.sv ***
module ht_address_window_filter
  import htw_pkg::*;
#(
  parameter int RXN = RX_WIN_N,
  parameter int PSN = POST_WIN_N,
  parameter int PFN = PREF_WIN_N,
  parameter int UCN = UNC_WIN_N
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 device_role_select_i,
  input  wire logic [RXN-1:0]       rx_win_en_i,
  input  wire logic [RXN*40-1:0]    rx_win_base_i,
  input  wire logic [RXN*40-1:0]    rx_win_mask_i,
  input  wire logic [PSN-1:0]       post_win_en_i,
  input  wire logic [PSN*40-1:0]    post_win_base_i,
  input  wire logic [PSN*40-1:0]    post_win_mask_i,
  input  wire logic [PFN-1:0]       pref_win_en_i,
  input  wire logic [PFN*40-1:0]    pref_win_base_i,
  input  wire logic [PFN*40-1:0]    pref_win_mask_i,
  input  wire logic [UCN-1:0]       unc_win_en_i,
  input  wire logic [UCN*40-1:0]    unc_win_base_i,
  input  wire logic [UCN*40-1:0]    unc_win_mask_i,
  input  wire logic                 rx_req_valid_i,
  input  wire logic [39:0]          rx_req_addr_i,
  input  wire logic                 rx_req_dma_i,
  input  wire logic                 rx_req_cfg_i,
  input  wire logic                 tx_req_valid_i,
  input  wire logic [39:0]          tx_req_addr_i,
  input  wire logic                 tx_req_write_i,
  input  wire logic                 tx_req_spec_i,
  input  wire logic                 tx_sent_i,
  output logic                      rx_route_valid_o,
  output rx_route_t                 rx_route_o,
  output logic                      rx_uncached_o,
  output logic                      tx_route_valid_o,
  output tx_route_t                 tx_route_o,
  output logic                      tx_early_done_o
);
  htw_win_if #(.N(RXN)) rx_w ();
  htw_win_if #(.N(PSN)) ps_w ();
  htw_win_if #(.N(PFN)) pf_w ();
  htw_win_if #(.N(UCN)) uc_w ();

  genvar g;
  generate
    for (g = 0; g < RXN; g++) begin : g_rx
      assign rx_w.base[g] = rx_win_base_i[g*40 +: 40];
      assign rx_w.mask[g] = rx_win_mask_i[g*40 +: 40];
    end
    for (g = 0; g < PSN; g++) begin : g_ps
      assign ps_w.base[g] = post_win_base_i[g*40 +: 40];
      assign ps_w.mask[g] = post_win_mask_i[g*40 +: 40];
    end
    for (g = 0; g < PFN; g++) begin : g_pf
      assign pf_w.base[g] = pref_win_base_i[g*40 +: 40];
      assign pf_w.mask[g] = pref_win_mask_i[g*40 +: 40];
    end
    for (g = 0; g < UCN; g++) begin : g_uc
      assign uc_w.base[g] = unc_win_base_i[g*40 +: 40];
      assign uc_w.mask[g] = unc_win_mask_i[g*40 +: 40];
    end
  endgenerate

  assign rx_w.en   = rx_win_en_i;
  assign rx_w.addr = rx_req_addr_i;
  assign ps_w.en   = post_win_en_i;
  assign ps_w.addr = tx_req_addr_i;
  assign pf_w.en   = pref_win_en_i;
  assign pf_w.addr = tx_req_addr_i;
  assign uc_w.en   = unc_win_en_i;
  assign uc_w.addr = rx_req_addr_i;

  htw_win_match #(.N(RXN)) u_rx (.w(rx_w));
  htw_win_match #(.N(PSN)) u_ps (.w(ps_w));
  htw_win_match #(.N(PFN)) u_pf (.w(pf_w));
  htw_win_match #(.N(UCN)) u_uc (.w(uc_w));

  // configuration space decode reuses the window matcher with one fixed window
  htw_win_if #(.N(1)) cf_w ();

  assign cf_w.en   = 1'b1;
  assign cf_w.base = CFG_BASE;
  assign cf_w.mask = CFG_SPAN_MASK;
  assign cf_w.addr = tx_req_addr_i;

  htw_win_match #(.N(1)) u_cf (.w(cf_w));

  // inbound decode terms
  logic      rx_hit;
  logic      rx_unc_hit;
  logic      rx_cfg_req;
  logic      rx_dma_req;
  logic      rx_dev_role;
  logic      rx_dma_unc;
  rx_route_t rx_route_next;
  logic      rx_uncached_next;

  // outbound decode terms
  logic      tx_cfg_hit;
  logic      tx_post_hit;
  logic      tx_pref_hit;
  logic      tx_is_write;
  logic      tx_is_spec_read;
  logic      tx_keep_local;
  logic      tx_make_posted;
  tx_route_t tx_route_next;

  // posted write completion tracking
  logic      tx_posted_req;
  logic      posted_pend_reg;
  logic      posted_pend_next;
  logic      early_done_next;

  assign rx_hit      = rx_w.hit;
  assign rx_unc_hit  = uc_w.hit;
  assign rx_cfg_req  = rx_req_cfg_i;
  assign rx_dma_req  = rx_req_dma_i;
  assign rx_dev_role = device_role_select_i;
  assign rx_dma_unc  = rx_dma_req && rx_unc_hit;

  assign tx_cfg_hit      = cf_w.hit;
  assign tx_post_hit     = ps_w.hit;
  assign tx_pref_hit     = pf_w.hit;
  assign tx_is_write     = tx_req_write_i;
  assign tx_is_spec_read = tx_req_spec_i && !tx_req_write_i;
  // speculative reads outside config space stay local unless a prefetch window lets them out
  assign tx_keep_local   = tx_is_spec_read && !tx_pref_hit;
  assign tx_make_posted  = tx_is_write && tx_post_hit;
  assign tx_posted_req   = tx_req_valid_i && (tx_route_next == TX_POSTED);

  // a link-side config access wins, then the windows, then the role decides
  always_comb begin
    if (rx_cfg_req) begin
      rx_route_next = RX_CONFIG;
    end else if (rx_hit) begin
      rx_route_next = RX_INTERNAL;
    end else if (rx_dev_role) begin
      rx_route_next = RX_ERROR;
    end else begin
      rx_route_next = RX_P2P;
    end
  end

  // coherent unless an uncache window hits a DMA access
  always_comb begin
    if (rx_dma_unc) begin
      rx_uncached_next = 1'b1;
    end else begin
      rx_uncached_next = 1'b0;
    end
  end

  // config space first; a speculative read kept local never reaches the link
  always_comb begin
    if (tx_cfg_hit) begin
      tx_route_next = TX_CONFIG;
    end else if (tx_keep_local) begin
      tx_route_next = TX_LOCAL;
    end else if (tx_make_posted) begin
      tx_route_next = TX_POSTED;
    end else begin
      tx_route_next = TX_NONPOSTED;
    end
  end

  // a new posted request wins over a send in the same cycle
  always_comb begin
    if (tx_posted_req) begin
      posted_pend_next = 1'b1;
    end else if (tx_sent_i) begin
      posted_pend_next = 1'b0;
    end else begin
      posted_pend_next = posted_pend_reg;
    end
  end

  // completion goes back when the write leaves, no link answer awaited
  assign early_done_next = posted_pend_reg && tx_sent_i;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_route_valid_o <= 1'b0;
    end else begin
      rx_route_valid_o <= rx_req_valid_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_route_o <= RX_INTERNAL;
    end else if (rx_req_valid_i) begin
      rx_route_o <= rx_route_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_uncached_o <= 1'b0;
    end else if (rx_req_valid_i) begin
      rx_uncached_o <= rx_uncached_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_route_valid_o <= 1'b0;
    end else begin
      tx_route_valid_o <= tx_req_valid_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_route_o <= TX_NONPOSTED;
    end else if (tx_req_valid_i) begin
      tx_route_o <= tx_route_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      posted_pend_reg <= 1'b0;
    end else begin
      posted_pend_reg <= posted_pend_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_early_done_o <= 1'b0;
    end else begin
      tx_early_done_o <= early_done_next;
    end
  end
endmodule : ht_address_window_filter

// *** bench/htw_peer.sv ***
module htw_peer (
  input  wire logic       mclk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] dly_i,
  output logic            sent_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial sent_o = 1'b0;
  // link sends a posted write dly_i cycles after it is routed
  always @(negedge mclk_i) begin
    sent_o <= (cnt == 1);
    cnt <= go_i ? int'(dly_i) : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule : htw_peer

// *** bench/htw_chk.sv ***
module htw_chk
  import htw_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        rx_req_valid_i,
  input wire logic        rx_req_cfg_i,
  input wire logic        tx_req_valid_i,
  input wire logic        tx_sent_i,
  input wire logic [39:0] tx_req_addr_i,
  input wire logic        rx_route_valid_o,
  input wire logic        tx_route_valid_o,
  input wire logic        tx_early_done_o,
  input wire rx_route_t   rx_route_o,
  input wire tx_route_t   tx_route_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  rx_lat_a: assert property (rx_req_valid_i |=> rx_route_valid_o) else $error("rx late");
  rx_only_a: assert property (!rx_req_valid_i |=> !rx_route_valid_o) else $error("rx spurious");
  tx_lat_a: assert property (tx_req_valid_i |=> tx_route_valid_o) else $error("tx late");
  tx_only_a: assert property (!tx_req_valid_i |=> !tx_route_valid_o) else $error("tx spurious");
  rx_cfg_a: assert property (rx_req_valid_i && rx_req_cfg_i |=> rx_route_o == RX_CONFIG)
    else $error("rx cfg route");
  tx_cfg_a: assert property (tx_req_valid_i && (tx_req_addr_i & CFG_SPAN_MASK) == CFG_BASE |=> tx_route_o == TX_CONFIG)
    else $error("tx cfg route");
  done_cause_a: assert property (tx_early_done_o |-> $past(tx_sent_i)) else $error("early done");
  rx_hold_a: assert property (!rx_req_valid_i |=> $stable(rx_route_o)) else $error("rx route moved");
endmodule : htw_chk
bind ht_address_window_filter htw_chk i_chk (.*);

// *** bench/testbench.sv ***
module testbench import htw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [39:0] M = 40'hFF_0000_0000;
  logic mclk_i = 0, rstn_i = 0, device_role_select_i = 0, tx_sent_i;
  logic rx_req_valid_i = 0, rx_req_dma_i = 0, rx_req_cfg_i = 0;
  logic tx_req_valid_i = 0, tx_req_write_i = 0, tx_req_spec_i = 0;
  logic [2:0]   rx_win_en_i = 3'h7;
  logic [1:0]   post_win_en_i = 2'h3, pref_win_en_i = 2'h3, unc_win_en_i = 2'h3;
  logic [119:0] rx_win_base_i = {40'h03_0000_0000, 40'h02_0000_0000, 40'h01_0000_0000}, rx_win_mask_i = {3{M}};
  logic [79:0]  post_win_base_i = {40'h11_0000_0000, 40'h10_0000_0000}, post_win_mask_i = {2{M}};
  logic [79:0]  pref_win_base_i = {40'h21_0000_0000, 40'h20_0000_0000}, pref_win_mask_i = {2{M}};
  logic [79:0]  unc_win_base_i = {40'h31_0000_0000, 40'h30_0000_0000}, unc_win_mask_i = {2{M}};
  logic [39:0]  rx_req_addr_i = 0, tx_req_addr_i = 0;
  logic rx_route_valid_o, rx_uncached_o, tx_route_valid_o, tx_early_done_o;
  rx_route_t rx_route_o;
  tx_route_t tx_route_o;
  logic [3:0] dly = 4'h1;
  int n_errors = 0, n_tests = 0, cyc = 0, i;
  ht_address_window_filter i_dut (.*);
  htw_peer i_peer (.mclk_i(mclk_i), .go_i(tx_route_valid_o && tx_route_o == TX_POSTED), .dly_i(dly),
    .sent_o(tx_sent_i));
  task chk(input logic [3:0] g, e);
    n_tests++;
    if (g !== e) begin
      $display("FAIL %0t %h %h", $time, g, e);
      n_errors++;
    end
  endtask : chk
  task rx(input logic [39:0] a, input logic d, c, input rx_route_t r, input logic u);
    @(negedge mclk_i) {rx_req_addr_i, rx_req_dma_i, rx_req_cfg_i, rx_req_valid_i} = {a, d, c, 1'b1};
    @(negedge mclk_i) rx_req_valid_i = 0;
    chk(rx_route_valid_o, 1);
    chk(rx_route_o, r);
    chk(rx_uncached_o, u);
  endtask : rx
  task tx(input logic [39:0] a, input logic w, s, input tx_route_t r);
    @(negedge mclk_i) {tx_req_addr_i, tx_req_write_i, tx_req_spec_i, tx_req_valid_i} = {a, w, s, 1'b1};
    @(negedge mclk_i) tx_req_valid_i = 0;
    chk(tx_route_valid_o, 1);
    chk(tx_route_o, r);
  endtask : tx
  task t_rx;
    rx(40'h01_0000_0100, 0, 0, RX_INTERNAL, 0);
    rx(40'h03_0000_0100, 1, 0, RX_INTERNAL, 0);
    rx(40'h05_0000_0000, 0, 0, RX_P2P, 0);
    rx(40'h30_0000_0000, 1, 0, RX_P2P, 1);
    rx(40'h31_0000_0000, 0, 0, RX_P2P, 0);
    rx(40'h05_0000_0000, 0, 1, RX_CONFIG, 0);
    rx_win_en_i = 3'h3;
    rx(40'h03_0000_0100, 0, 0, RX_P2P, 0);
    device_role_select_i = 1;
    rx(40'h02_0000_0000, 0, 0, RX_INTERNAL, 0);
    rx(40'h03_0000_0000, 0, 0, RX_ERROR, 0);
    {device_role_select_i, rx_win_en_i} = 4'h7;
    $display("t_rx done");
  endtask : t_rx
  task t_tx;
    for (int j = 0; j < 4; j++) begin
      dly = 4'h1 << j;
      tx(40'h10_0000_0040 + (j % 2) * 40'h01_0000_0000, 1, 0, TX_POSTED);
      for (i = 0; i < 12 && tx_early_done_o !== 1; i++) @(negedge mclk_i);
      chk(tx_early_done_o, 1);
      chk(4'(i), dly + 4'h1);
    end
    tx(40'h12_0000_0000, 1, 0, TX_NONPOSTED);
    tx(40'h40_0000_0000, 0, 1, TX_LOCAL);
    tx(40'h20_0000_0000, 0, 1, TX_NONPOSTED);
    tx(40'h21_0000_0000, 0, 1, TX_NONPOSTED);
    tx(40'hFD_FB00_0000, 1, 0, TX_CONFIG);
    tx(40'hFD_FBFF_FFFF, 0, 1, TX_CONFIG);
    tx(40'hFD_FC00_0000, 0, 0, TX_NONPOSTED);
    tx(40'hFD_FAFF_FFFF, 0, 0, TX_NONPOSTED);
    $display("t_tx done");
  endtask : t_tx
  task t_reset;
    @(negedge mclk_i) rstn_i = 0;
    @(negedge mclk_i);
    chk(rx_route_o, RX_INTERNAL);
    chk(tx_route_o, TX_NONPOSTED);
    chk({rx_route_valid_o, rx_uncached_o, tx_route_valid_o, tx_early_done_o}, 4'h0);
    rstn_i = 1;
    rx(40'h05_0000_0000, 0, 0, RX_P2P, 0);
    $display("t_reset done");
  endtask : t_reset
  task report_and_stop;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial forever #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(negedge mclk_i);
    rstn_i = 1;
    t_rx;
    t_tx;
    t_reset;
    report_and_stop;
  end
endmodule : testbench
